// ### logic/svr_regs.sv
// Status registers and indirectly written VCO subsystem registers.
// Assumes serial framing is decoded outside: WR_STB pulses once per complete
// main-register word, RD_DATA is registered from RD_ADDR and lags it by one clock.
`timescale 1ns/1ps

module svr_regs
    import svr_pkg::*;
#(
    parameter int SIG_W = 16
) (
    // Clock and reset
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    // Main register write port
    input  wire logic                  WR_STB,
    input  wire logic [4:0]            WR_ADDR,
    input  wire logic [SVR_DATA_W-1:0] WR_DATA,
    // Main register read port
    input  wire logic [4:0]            RD_ADDR,
    output logic      [SVR_DATA_W-1:0] RD_DATA,
    output logic                       RD_HIT,
    // Device state sampled into status
    input  wire logic                  GPO_STATE,
    input  wire logic                  LOCKED,
    input  wire logic [SIG_W-1:0]      SELF_TEST_SIG,
    input  wire logic                  SELF_TEST_BUSY,
    // VCO subsystem controls
    output logic                       CAL_SELECT,
    output logic      [7:0]            SUBBAND_SELECT,
    output logic      [5:0]            DIVIDE_RATIO,
    output svr_enables_t               BLOCK_EN,
    output logic                       MANUAL_OUTPUT_MODE
);

    initial begin
        if (SIG_W != 16) begin
            $error("SIG_W must be 16");
        end
    end

    // ****************************************
    // Indirect write decode
    // ****************************************
    svr_indirect_t ind;
    logic          ind_wr;
    logic          wr_tuning;
    logic          wr_enables;
    logic          wr_biases;
    logic          wr_config;

    assign ind = svr_indirect_t'(WR_DATA[SVR_PAY_LSB+SVR_VDATA_W-1:SVR_ID_LSB]);
    assign ind_wr = WR_STB && (WR_ADDR == SVR_ADDR_INDIRECT)
                    && (ind.sub_id == SVR_VCO_ID);
    assign wr_tuning  = ind_wr && (ind.vaddr == SVR_VCO_TUNING);
    assign wr_enables = ind_wr && (ind.vaddr == SVR_VCO_ENABLES);
    assign wr_biases  = ind_wr && (ind.vaddr == SVR_VCO_BIASES);
    assign wr_config  = ind_wr && (ind.vaddr == SVR_VCO_CONFIG);

    // ****************************************
    // VCO subsystem registers
    // ****************************************
    logic [8:0] tuning_reg;
    logic [8:0] enables_reg;
    logic [8:0] biases_reg;
    logic [8:0] config_reg;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tuning_reg  <= SVR_TUNING_RST;
            enables_reg <= SVR_ENABLES_RST;
            biases_reg  <= SVR_BIASES_RST;
            config_reg  <= SVR_CONFIG_RST;
        end else begin
            if (wr_tuning) begin
                tuning_reg <= ind.payload;
            end
            if (wr_enables) begin
                enables_reg <= ind.payload;
            end
            if (wr_biases) begin
                biases_reg <= ind.payload;
            end
            if (wr_config) begin
                config_reg <= ind.payload;
            end
        end
    end

    // ****************************************
    // Divide ratio and enable resolution
    // ****************************************
    logic [5:0]   ratio_raw;
    logic [5:0]   ratio_eff;
    logic         master_en;
    logic         manual;
    logic         div_mute;
    logic         div_is_one;
    svr_enables_t en_next;

    assign ratio_raw  = biases_reg[SVR_RATIO_MSB:0];
    assign ratio_eff  = (ratio_raw > SVR_DIV_MAX) ? SVR_DIV_MAX :
                        (ratio_raw > SVR_DIV_ONE) ? {ratio_raw[5:1], 1'b0} : ratio_raw;
    assign master_en  = enables_reg[SVR_EN_MASTER];
    assign manual     = config_reg[SVR_MANUAL_BIT];
    assign div_mute   = (ratio_eff == SVR_DIV_MUTE);
    assign div_is_one = (ratio_eff == SVR_DIV_ONE);

    always_comb begin
        en_next = '0;
        if (master_en && manual) begin
            en_next.vco_on  = 1'b1;
            en_next.pll_buf = enables_reg[SVR_EN_PLL];
            en_next.rf_buf  = enables_reg[SVR_EN_RF];
            en_next.div_one = enables_reg[SVR_EN_ONE];
            en_next.rf_div  = enables_reg[SVR_EN_DIV];
        end else if (master_en) begin
            en_next.vco_on  = 1'b1;
            en_next.pll_buf = 1'b1;
            en_next.rf_buf  = !div_mute;
            en_next.div_one = div_is_one;
            en_next.rf_div  = !div_mute && !div_is_one;
        end
    end

    // ****************************************
    // Registered control outputs
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CAL_SELECT         <= 1'b0;
            SUBBAND_SELECT     <= 8'h00;
            DIVIDE_RATIO       <= 6'h00;
            BLOCK_EN           <= '0;
            MANUAL_OUTPUT_MODE <= 1'b0;
        end else begin
            CAL_SELECT         <= tuning_reg[SVR_CAL_BIT];
            SUBBAND_SELECT     <= tuning_reg[SVR_SUB_MSB:SVR_SUB_LSB];
            DIVIDE_RATIO       <= ratio_eff;
            BLOCK_EN           <= en_next;
            MANUAL_OUTPUT_MODE <= manual;
        end
    end

    // ****************************************
    // Status readback
    // ****************************************
    logic [SVR_DATA_W-1:0] out_lock_word;
    logic [SVR_DATA_W-1:0] self_test_word;
    logic [SVR_DATA_W-1:0] rd_next;

    assign out_lock_word  = {{(SVR_DATA_W-2){1'b0}}, LOCKED, GPO_STATE};
    assign self_test_word = {{(SVR_DATA_W-SVR_BUSY_BIT-1){1'b0}},
                             SELF_TEST_BUSY, SELF_TEST_SIG};
    assign RD_HIT  = (RD_ADDR == SVR_ADDR_OUT_LOCK) || (RD_ADDR == SVR_ADDR_SELF_TEST);
    assign rd_next = (RD_ADDR == SVR_ADDR_OUT_LOCK)  ? out_lock_word :
                     (RD_ADDR == SVR_ADDR_SELF_TEST) ? self_test_word : '0;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RD_DATA <= '0;
        end else begin
            RD_DATA <= rd_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    status_bits_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_OUT_LOCK |=> RD_DATA[0] == $past(GPO_STATE))
        else $error("gpo status bit wrong");
    lock_bit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_OUT_LOCK |=> RD_DATA[1] == $past(LOCKED))
        else $error("lock status bit wrong");
    self_test_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_SELF_TEST |=>
        RD_DATA[16:0] == $past({SELF_TEST_BUSY, SELF_TEST_SIG}))
        else $error("self test word wrong");
    other_id_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        WR_STB && ind.sub_id != SVR_VCO_ID |=> $stable(tuning_reg) && $stable(enables_reg))
        else $error("foreign subsystem write took effect");
    tuning_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_tuning |=> ##1 SUBBAND_SELECT == $past(ind.payload[8:1], 2))
        else $error("tuning write not forwarded");
    master_off_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !master_en |=> BLOCK_EN == '0)
        else $error("blocks on with master off");
    manual_and_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual |=> BLOCK_EN.rf_buf == $past(enables_reg[2]))
        else $error("manual enable not honoured");
    auto_mute_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual && div_mute |=> !BLOCK_EN.rf_buf && BLOCK_EN.pll_buf)
        else $error("mute ratio did not mute");
    ratio_clamp_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ratio_raw > SVR_DIV_MAX |=> DIVIDE_RATIO == SVR_DIV_MAX)
        else $error("ratio not clamped");
    auto_one_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual && div_is_one |=> BLOCK_EN.div_one && !BLOCK_EN.rf_div)
        else $error("divide by one path wrong");

    // ****************************************
    // Indirect write checks
    // ****************************************
    // Stored words change only on an accepted indirect write
    enables_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_enables |=> enables_reg == $past(ind.payload))
        else $error("enables write not stored");

    biases_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_biases |=> biases_reg == $past(ind.payload))
        else $error("biases write not stored");

    config_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_config |=> config_reg == $past(ind.payload))
        else $error("config write not stored");

    no_strobe_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !WR_STB |=> $stable(tuning_reg) && $stable(enables_reg)
                    && $stable(biases_reg) && $stable(config_reg))
        else $error("register changed without strobe");

    other_addr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        WR_STB && WR_ADDR != SVR_ADDR_INDIRECT |=> $stable(tuning_reg)
            && $stable(enables_reg) && $stable(biases_reg) && $stable(config_reg))
        else $error("direct write reached subsystem");

    other_vaddr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ind_wr && ind.vaddr > SVR_VCO_CONFIG |=> $stable(tuning_reg)
            && $stable(enables_reg) && $stable(biases_reg) && $stable(config_reg))
        else $error("unstored address changed a register");

    other_id_rest_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        WR_STB && ind.sub_id != SVR_VCO_ID |=> $stable(biases_reg) && $stable(config_reg))
        else $error("foreign subsystem write took effect");

    tuning_cal_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        wr_tuning |=> ##1 CAL_SELECT == $past(ind.payload[SVR_CAL_BIT], 2))
        else $error("calibration bit not forwarded");

    cal_follow_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> CAL_SELECT == $past(tuning_reg[SVR_CAL_BIT]))
        else $error("calibration select stale");

    subband_follow_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> SUBBAND_SELECT == $past(tuning_reg[SVR_SUB_MSB:SVR_SUB_LSB]))
        else $error("sub-band select stale");

    // ****************************************
    // Enable resolution checks
    // ****************************************
    manual_vco_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual |=> BLOCK_EN.vco_on)
        else $error("oscillator off in manual mode");

    manual_pll_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual |=> BLOCK_EN.pll_buf == $past(enables_reg[SVR_EN_PLL]))
        else $error("manual pll buffer enable wrong");

    manual_one_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual |=> BLOCK_EN.div_one == $past(enables_reg[SVR_EN_ONE]))
        else $error("manual divide by one enable wrong");

    manual_div_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual |=> BLOCK_EN.rf_div == $past(enables_reg[SVR_EN_DIV]))
        else $error("manual divider enable wrong");

    rf_mute_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual && !enables_reg[SVR_EN_RF] |=> !BLOCK_EN.rf_buf)
        else $error("cleared buffer enable did not mute");

    manual_ratio_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && manual && ratio_raw == SVR_DIV_MUTE && enables_reg[SVR_EN_RF]
        |=> BLOCK_EN.rf_buf)
        else $error("ratio acted in manual mode");

    auto_override_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual |=> BLOCK_EN.vco_on && BLOCK_EN.pll_buf)
        else $error("automatic mode not overriding");

    auto_rfbuf_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual |=> BLOCK_EN.rf_buf == ($past(ratio_raw) != SVR_DIV_MUTE))
        else $error("automatic buffer enable wrong");

    auto_div_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual && ratio_raw > SVR_DIV_ONE |=> BLOCK_EN.rf_div && !BLOCK_EN.div_one)
        else $error("automatic divider enable wrong");

    auto_one_buf_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual && ratio_raw == SVR_DIV_ONE |=> BLOCK_EN.rf_buf && BLOCK_EN.div_one)
        else $error("divide by one buffer wrong");

    mute_stages_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en && !manual && ratio_raw == SVR_DIV_MUTE
        |=> BLOCK_EN.vco_on && !BLOCK_EN.rf_div && !BLOCK_EN.div_one)
        else $error("mute left output stages on");

    master_on_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        master_en |=> BLOCK_EN.vco_on)
        else $error("oscillator off with master on");

    mode_out_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> MANUAL_OUTPUT_MODE == $past(manual))
        else $error("mode output stale");

    // ****************************************
    // Ratio and readback checks
    // ****************************************
    ratio_even_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ratio_raw > SVR_DIV_ONE |=> DIVIDE_RATIO[0] == 1'b0)
        else $error("odd ratio not rounded");

    ratio_pass_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ratio_raw <= SVR_DIV_ONE |=> DIVIDE_RATIO == $past(ratio_raw))
        else $error("low ratio altered");

    ratio_round_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ratio_raw > SVR_DIV_ONE && ratio_raw <= SVR_DIV_MAX
        |=> DIVIDE_RATIO == ($past(ratio_raw) & ~SVR_DIV_ONE))
        else $error("ratio rounding wrong");

    rd_other_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        !RD_HIT |=> RD_DATA == '0)
        else $error("unmapped read not zero");

    lock_upper_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_OUT_LOCK |=> RD_DATA[SVR_DATA_W-1:2] == '0)
        else $error("status upper bits set");

    st_upper_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_SELF_TEST |=> RD_DATA[SVR_DATA_W-1:SVR_BUSY_BIT+1] == '0)
        else $error("self test upper bits set");

    busy_bit_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        RD_ADDR == SVR_ADDR_SELF_TEST |=> RD_DATA[SVR_BUSY_BIT] == $past(SELF_TEST_BUSY))
        else $error("busy flag wrong");

endmodule

// ### logic/svr_pkg.sv
// Package for the synthesizer status and VCO indirect register block.
// Assumes a register interface that delivers complete main-register words.
package svr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] SVR_ADDR_INDIRECT  = 5'h05;
    localparam logic [4:0] SVR_ADDR_OUT_LOCK  = 5'h12;
    localparam logic [4:0] SVR_ADDR_SELF_TEST = 5'h13;
    localparam logic [3:0] SVR_VCO_TUNING     = 4'h0;
    localparam logic [3:0] SVR_VCO_ENABLES    = 4'h1;
    localparam logic [3:0] SVR_VCO_BIASES     = 4'h2;
    localparam logic [3:0] SVR_VCO_CONFIG     = 4'h3;
    localparam logic [2:0] SVR_VCO_ID         = 3'h0;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int SVR_DATA_W    = 24;
    localparam int SVR_VDATA_W   = 9;
    localparam int SVR_ID_LSB    = 0;
    localparam int SVR_ADDR_LSB  = 3;
    localparam int SVR_PAY_LSB   = 7;
    localparam int SVR_BUSY_BIT  = 16;
    localparam int SVR_MANUAL_BIT = 2;
    localparam int SVR_CAL_BIT    = 0;
    localparam int SVR_SUB_LSB    = 1;
    localparam int SVR_SUB_MSB    = 8;
    localparam int SVR_RATIO_MSB  = 5;
    localparam int SVR_EN_MASTER  = 0;
    localparam int SVR_EN_PLL     = 1;
    localparam int SVR_EN_RF      = 2;
    localparam int SVR_EN_ONE     = 3;
    localparam int SVR_EN_DIV     = 4;
    localparam logic [8:0] SVR_TUNING_RST  = 9'h020;
    localparam logic [8:0] SVR_ENABLES_RST = 9'h01F;
    localparam logic [8:0] SVR_BIASES_RST  = 9'h0C1;
    localparam logic [8:0] SVR_CONFIG_RST  = 9'h041;
    localparam logic [5:0] SVR_DIV_MUTE    = 6'h00;
    localparam logic [5:0] SVR_DIV_ONE     = 6'h01;
    localparam logic [5:0] SVR_DIV_MAX     = 6'h3E;

    // Decoded word written to main register 05h
    typedef struct packed {
        logic [8:0] payload;
        logic [3:0] vaddr;
        logic [2:0] sub_id;
    } svr_indirect_t;

    // Enables driven into the VCO subsystem
    typedef struct packed {
        logic vco_on;
        logic pll_buf;
        logic rf_buf;
        logic div_one;
        logic rf_div;
    } svr_enables_t;

endpackage

// ### sim/svr_host.sv
// Host model: writes whole main-register words and reads status back.
// Assumes the block takes a write on the edge that sees WR_STB high.
`timescale 1ns/1ps

module svr_host_model
    import svr_pkg::*;
(
    // Clock and read return
    input  wire logic                  CLK_SYS,
    input  wire logic [SVR_DATA_W-1:0] RD_DATA,
    // Requests
    output logic                       WR_STB,
    output logic      [4:0]            WR_ADDR,
    output logic      [SVR_DATA_W-1:0] WR_DATA,
    output logic      [4:0]            RD_ADDR
);
    initial begin
        WR_STB  = 1'b0;
        WR_ADDR = 5'h00;
        WR_DATA = 24'h000000;
        RD_ADDR = 5'h00;
    end

    // Data is scrambled once the strobe drops, so stale words never look valid
    task automatic main_write(input logic [4:0] addr, input logic [SVR_DATA_W-1:0] data);
        @(posedge CLK_SYS);
        WR_STB  <= 1'b1;
        WR_ADDR <= addr;
        WR_DATA <= data;
        @(posedge CLK_SYS);
        WR_STB  <= 1'b0;
        WR_DATA <= ~data;
    endtask

    task automatic vco_write(input logic [2:0] id, input logic [3:0] vaddr, input logic [8:0] pay);
        main_write(SVR_ADDR_INDIRECT, {8'h00, pay, vaddr, id});
    endtask

    task automatic main_read(input logic [4:0] addr, output logic [SVR_DATA_W-1:0] data);
        @(posedge CLK_SYS);
        RD_ADDR <= addr;
        repeat (2) @(posedge CLK_SYS);
        #1;
        data = RD_DATA;
    endtask
endmodule

// ### sim/tb.sv
// Testbench for the status and VCO indirect register block.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb
    import svr_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         gpo_state = 1'b0;
    logic         locked = 1'b0;
    logic [15:0]  self_test_sig = 16'h0000;
    logic         self_test_busy = 1'b0;
    logic         wr_stb, rd_hit, cal, manual;
    logic [4:0]   wr_addr, rd_addr;
    logic [23:0]  wr_data, rd_data, rd;
    logic [7:0]   subband;
    logic [5:0]   ratio;
    svr_enables_t block_en;
    int           failures = 0;
    int           n_compared = 0;
    logic [5:0]   r_in  [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h3D, 6'h3F, 6'h3E};
    logic [5:0]   r_exp [8] = '{6'h00, 6'h01, 6'h02, 6'h02, 6'h04, 6'h3C, 6'h3E, 6'h3E};

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    svr_host_model host_u (.CLK_SYS(clk_sys), .RD_DATA(rd_data), .WR_STB(wr_stb),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr));

    svr_regs dut_u (.CLK_SYS(clk_sys), .RST(rst), .WR_STB(wr_stb), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_HIT(rd_hit),
        .GPO_STATE(gpo_state), .LOCKED(locked), .SELF_TEST_SIG(self_test_sig),
        .SELF_TEST_BUSY(self_test_busy), .CAL_SELECT(cal), .SUBBAND_SELECT(subband),
        .DIVIDE_RATIO(ratio), .BLOCK_EN(block_en), .MANUAL_OUTPUT_MODE(manual));

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Controls follow a write one edge after it is taken
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // Enable word written in full, then checked
    task automatic en_case(input logic [8:0] pay, input logic [4:0] ex);
        host_u.vco_write(SVR_VCO_ID, SVR_VCO_ENABLES, pay);
        settle();
        `CHK("block_en", ex, block_en)
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        `CHK("cal", 1'b0, cal)
        `CHK("subband", 8'h10, subband)
        `CHK("block_en", 5'h1E, block_en)
        `CHK("ratio", 6'h01, ratio)
        `CHK("manual", 1'b0, manual)
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            gpo_state <= k[0];
            locked <= k[1];
            self_test_sig <= {k[1:0], 14'h15A3};
            self_test_busy <= k[0];
            host_u.main_read(SVR_ADDR_OUT_LOCK, rd);
            `CHK("out_lock", {22'h0, k[1], k[0]}, rd)
            `CHK("rd_hit", 1'b1, rd_hit)
            host_u.main_read(SVR_ADDR_SELF_TEST, rd);
            `CHK("self_test", {7'h00, k[0], k[1:0], 14'h15A3}, rd)
        end
        host_u.main_read(SVR_ADDR_INDIRECT, rd);
        `CHK("rd_hit", 1'b0, rd_hit)
        $display("status test done");
        host_u.vco_write(SVR_VCO_ID, SVR_VCO_TUNING, 9'h1FF);
        settle();
        `CHK("cal", 1'b1, cal)
        `CHK("subband", 8'hFF, subband)
        host_u.vco_write(SVR_VCO_ID, SVR_VCO_TUNING, 9'h002);
        settle();
        `CHK("cal", 1'b0, cal)
        `CHK("subband", 8'h01, subband)
        $display("tuning test done");
        for (int j = 0; j < 8; j++) begin
            host_u.vco_write(SVR_VCO_ID, SVR_VCO_BIASES, {3'h3, r_in[j]});
            settle();
            `CHK("ratio", r_exp[j], ratio)
            `CHK("auto_en", {2'b11, r_exp[j] != 0, r_exp[j] == 1, r_exp[j] >= 2}, block_en)
        end
        host_u.vco_write(3'h1, SVR_VCO_BIASES, 9'h000);
        host_u.vco_write(SVR_VCO_ID, 4'h7, 9'h000);
        host_u.main_write(5'h06, 24'h000010);
        settle();
        `CHK("ratio", 6'h3E, ratio)
        $display("ratio test done");
        en_case(9'h01E, 5'h00);
        en_case(9'h001, 5'h1D);
        host_u.vco_write(SVR_VCO_ID, SVR_VCO_CONFIG, 9'h045);
        settle();
        `CHK("manual", 1'b1, manual)
        `CHK("block_en", 5'h10, block_en)
        host_u.main_write(SVR_ADDR_INDIRECT, 24'h000D88);
        settle();
        `CHK("block_en", 5'h1B, block_en)
        host_u.vco_write(SVR_VCO_ID, SVR_VCO_BIASES, 9'h0C0);
        settle();
        `CHK("block_en", 5'h1B, block_en)
        en_case(9'h01E, 5'h00);
        $display("enable test done");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        `CHK("cal", 1'b0, cal)
        `CHK("subband", 8'h10, subband)
        `CHK("block_en", 5'h1E, block_en)
        `CHK("ratio", 6'h01, ratio)
        $display("mid-run reset test done");
        final_report();
    end
endmodule
